// ### hdl/tei_pkg.sv
/*
 * shared constants and carrier types for the terminal escape interpreter.
 * assumes one 125 MHz clock and a synchronous, active-high reset.
 */
package tei_pkg;

	// ------------------------------------------------------------------
	// screen geometry
	// ------------------------------------------------------------------
	localparam int unsigned SCR_COLS     = 80;
	localparam int unsigned SCR_ROWS     = 24;
	localparam int unsigned BUF_ROWS     = 96;
	localparam int unsigned BUF_SCREENS  = 4;
	localparam logic [6:0]  LAST_COL     = 7'h4F;  // column 80, zero based
	localparam logic [4:0]  LAST_ROW     = 5'h17;  // row 24, zero based
	localparam logic [6:0]  TOP_LAST     = 7'h48;  // top row index of the fourth screen
	localparam logic [6:0]  HOME_COL     = 7'h00;
	localparam logic [4:0]  HOME_ROW     = 5'h00;
	localparam logic [6:0]  TOP_RST      = 7'h00;

	// ------------------------------------------------------------------
	// character codes, seven bit
	// ------------------------------------------------------------------
	localparam logic [6:0]  CH_ENQ       = 7'h05;
	localparam logic [6:0]  CH_ACK       = 7'h06;
	localparam logic [6:0]  CH_BEL       = 7'h07;
	localparam logic [6:0]  CH_BS        = 7'h08;
	localparam logic [6:0]  CH_LF        = 7'h0A;
	localparam logic [6:0]  CH_CR        = 7'h0D;
	localparam logic [6:0]  CH_ESC       = 7'h1B;
	localparam logic [6:0]  CH_SPACE     = 7'h20;
	localparam logic [6:0]  CH_LBRACKET  = 7'h5B;
	localparam logic [6:0]  CH_SEMI      = 7'h3B;
	localparam logic [6:0]  CH_ZERO      = 7'h30;
	localparam logic [6:0]  CH_NINE      = 7'h39;
	localparam logic [6:0]  CH_SEVEN     = 7'h37;
	localparam logic [6:0]  CH_EIGHT     = 7'h38;
	localparam logic [6:0]  CH_UP_A      = 7'h41;
	localparam logic [6:0]  CH_UP_B      = 7'h42;
	localparam logic [6:0]  CH_UP_C      = 7'h43;
	localparam logic [6:0]  CH_UP_D      = 7'h44;
	localparam logic [6:0]  CH_UP_E      = 7'h45;
	localparam logic [6:0]  CH_UP_H      = 7'h48;
	localparam logic [6:0]  CH_UP_J      = 7'h4A;
	localparam logic [6:0]  CH_UP_K      = 7'h4B;
	localparam logic [6:0]  CH_UP_M      = 7'h4D;
	localparam logic [6:0]  CH_LO_C      = 7'h63;
	localparam logic [6:0]  CH_LO_F      = 7'h66;

	// ------------------------------------------------------------------
	// buffering and parameters
	// ------------------------------------------------------------------
	localparam int unsigned FIFO_DEPTH   = 32;
	localparam int unsigned CHAR_W       = 7;
	localparam logic [7:0]  PARAM_MAX    = 8'hFF;  // accumulator saturates here

	// blanking span selectors
	localparam logic [1:0]  SEL_TO_END   = 2'h0;
	localparam logic [1:0]  SEL_TO_CUR   = 2'h1;
	localparam logic [1:0]  SEL_ALL      = 2'h2;

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	// cursor: visible row, column and top row of the visible window in the buffer
	typedef struct packed {
		logic [4:0] row;
		logic [6:0] col;
		logic [6:0] top;
	} tei_cursor_type;

	// blanking request: absolute buffer rows and columns, inclusive span
	typedef struct packed {
		logic [6:0] row_first;
		logic [6:0] row_last;
		logic [6:0] col_first;
		logic [6:0] col_last;
	} tei_blank_type;

endpackage

// ### hdl/tei_fifo.sv
/*
 * synchronous fifo of flip-flops, width and depth as parameters.
 * assumes both sides on clk_in; depth is a power of two.
 */
module tei_fifo
	import tei_pkg::*;
#(
	parameter int unsigned WIDTH = 7,
	parameter int unsigned DEPTH = 32
) (
	input  wire logic             clk_in,
	input  wire logic             sys_rst_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	input  wire logic             wr_valid_in,
	output logic                  wr_ready_out,
	output logic      [WIDTH-1:0] rd_data_out,
	output logic                  rd_valid_out,
	input  wire logic             rd_ready_in
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0]      wr_ptr_r;
	logic [AW:0]      wr_ptr_nxt;
	logic [AW:0]      rd_ptr_r;
	logic [AW:0]      rd_ptr_nxt;
	logic             push;
	logic             pop;

	// ------------------------------------------------------------------
	// flags and pointer steps
	// ------------------------------------------------------------------
	assign wr_ready_out = (wr_ptr_r - rd_ptr_r) != (AW+1)'(DEPTH);
	assign rd_valid_out = wr_ptr_r != rd_ptr_r;
	assign push         = wr_valid_in && wr_ready_out;
	assign pop          = rd_valid_out && rd_ready_in;
	assign rd_data_out  = mem_r[rd_ptr_r[AW-1:0]];

	always_comb begin
		wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
		rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
	end

	// storage and pointers
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_r[wr_ptr_r[AW-1:0]] <= wr_data_in;
		end
		if (sys_rst_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
		end
	end

endmodule

// ### hdl/tei_interp.sv
/*
 * terminal escape interpreter: parses received characters, moves the cursor,
 * issues blanking requests, acknowledge, beep and reset/self-test strobes.
 * assumes received characters arrive with valid/ready from a uart on clk_in,
 * and that the screen memory takes one blanking request per blank_valid_out.
 */
module tei_interp
	import tei_pkg::*;
(
	input  wire logic               clk_in,
	input  wire logic               sys_rst_in,
	input  wire logic [7:0]         rx_data_in,
	input  wire logic               rx_valid_in,
	output logic                    rx_ready_out,
	output logic      [6:0]         tx_data_out,
	output logic                    tx_valid_out,
	input  wire logic               tx_ready_in,
	output logic      [6:0]         disp_data_out,
	output logic                    disp_valid_out,
	output tei_cursor_type          cursor_out,
	output tei_blank_type           blank_out,
	output logic                    blank_valid_out,
	input  wire logic               blank_ready_in,
	output logic                    beep_out,
	output logic                    self_test_out
);

	typedef enum logic [3:0] {
		ST_GROUND  = 4'b0001,
		ST_ESCAPE  = 4'b0010,
		ST_PARAM   = 4'b0100,
		ST_BLANK   = 4'b1000
	} tei_state_type;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	// parameter value with default when omitted or zero
	function automatic logic [7:0] count_of(input logic [7:0] v, input logic seen);
		count_of = (!seen || v == 8'h00) ? 8'h01 : v;
	endfunction

	// saturating decimal accumulate
	function automatic logic [7:0] accum(input logic [7:0] v, input logic [6:0] ch);
		logic [11:0] t;
		t = 12'(v) * 12'h00A + 12'(ch - CH_ZERO);
		accum = (t > 12'(PARAM_MAX)) ? PARAM_MAX : t[7:0];
	endfunction

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	tei_state_type  state_r, state_nxt;
	tei_cursor_type cur_r, cur_nxt;
	tei_cursor_type saved_r, saved_nxt;
	logic [7:0]     first_parameter_r, first_parameter_nxt;
	logic [7:0]     second_parameter_r, second_parameter_nxt;
	logic           first_seen_r, first_seen_nxt;
	logic           second_seen_r, second_seen_nxt;
	logic           in_second_r, in_second_nxt;
	tei_blank_type  blank_r, blank_nxt;
	logic           tx_pend_r, tx_pend_nxt;
	logic           beep_r, beep_nxt;
	logic           test_r, test_nxt;
	logic [6:0]     disp_r, disp_nxt;
	logic           disp_v_r, disp_v_nxt;

	// input buffering between the uart and the parser
	logic [6:0]     ch;
	logic           ch_valid;
	logic           ch_take;

	tei_fifo #(
		.WIDTH (CHAR_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in       (clk_in),
		.sys_rst_in   (sys_rst_in),
		.wr_data_in   (rx_data_in[6:0]),  // bit 7 dropped: seven-bit codes
		.wr_valid_in  (rx_valid_in),
		.wr_ready_out (rx_ready_out),
		.rd_data_out  (ch),
		.rd_valid_out (ch_valid),
		.rd_ready_in  (ch_take)
	);

	// parser stalls while a blank request or an ack is still pending
	assign ch_take = ch_valid && state_r != ST_BLANK && !tx_pend_r;

	// ------------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		logic [7:0] n;
		logic [6:0] abs_row;
		logic [7:0] tmp;
		n = count_of(first_parameter_r, first_seen_r);
		abs_row = cur_r.top + 7'(cur_r.row);
		tmp = 8'h00;
		state_nxt = state_r;
		cur_nxt = cur_r;
		saved_nxt = saved_r;
		first_parameter_nxt = first_parameter_r;
		second_parameter_nxt = second_parameter_r;
		first_seen_nxt = first_seen_r;
		second_seen_nxt = second_seen_r;
		in_second_nxt = in_second_r;
		blank_nxt = blank_r;
		tx_pend_nxt = tx_pend_r && !tx_ready_in;
		beep_nxt = 1'b0;
		test_nxt = 1'b0;
		disp_nxt = disp_r;
		disp_v_nxt = 1'b0;
		if (state_r == ST_BLANK) begin
			if (blank_ready_in) begin
				state_nxt = ST_GROUND;
			end
		end else if (ch_take) begin
			unique case (state_r)
				ST_GROUND: begin
					if (ch == CH_ESC) begin
						state_nxt = ST_ESCAPE;
					end else if (ch == CH_ENQ) begin
						tx_pend_nxt = 1'b1;
					end else if (ch == CH_BEL) begin
						beep_nxt = 1'b1;
					end else if (ch == CH_BS) begin
						if (cur_r.col != HOME_COL) cur_nxt.col = cur_r.col - 7'h01;
					end else if (ch == CH_LF) begin
						if (cur_r.row != LAST_ROW) cur_nxt.row = cur_r.row + 5'h01;
					end else if (ch == CH_CR) begin
						cur_nxt.col = HOME_COL;
					end else if (ch >= CH_SPACE && ch != 7'h7F) begin
						disp_nxt = ch;
						disp_v_nxt = 1'b1;
						if (cur_r.col != LAST_COL) cur_nxt.col = cur_r.col + 7'h01;
					end
					// other control codes fall through untouched
				end
				ST_ESCAPE: begin
					state_nxt = ST_GROUND;
					first_parameter_nxt = 8'h00;
					second_parameter_nxt = 8'h00;
					first_seen_nxt = 1'b0;
					second_seen_nxt = 1'b0;
					in_second_nxt = 1'b0;
					if (ch == CH_LBRACKET) begin
						state_nxt = ST_PARAM;
					end else if (ch == CH_SEVEN) begin
						saved_nxt = cur_r;
					end else if (ch == CH_EIGHT) begin
						cur_nxt = saved_r;
					end else if (ch == CH_UP_D || ch == CH_UP_E) begin
						if (ch == CH_UP_E) cur_nxt.col = HOME_COL;
						if (cur_r.row != LAST_ROW) begin
							cur_nxt.row = cur_r.row + 5'h01;
						end else if (cur_r.top != TOP_LAST) begin
							cur_nxt.top = cur_r.top + 7'h01;  // scroll within buffer
						end
					end else if (ch == CH_UP_M) begin
						if (cur_r.row != HOME_ROW) begin
							cur_nxt.row = cur_r.row - 5'h01;
						end else if (cur_r.top != TOP_RST) begin
							cur_nxt.top = cur_r.top - 7'h01;
						end
					end else if (ch == CH_LO_C) begin
						cur_nxt = '{row: HOME_ROW, col: HOME_COL, top: TOP_RST};
						saved_nxt = '{row: HOME_ROW, col: HOME_COL, top: TOP_RST};
						blank_nxt = '{row_first: 7'h00, row_last: 7'(BUF_ROWS - 1),
							col_first: HOME_COL, col_last: LAST_COL};
						state_nxt = ST_BLANK;
						test_nxt = 1'b1;
					end
					// anything else ends the sequence with no effect
				end
				ST_PARAM: begin
					state_nxt = ST_GROUND;
					if (ch >= CH_ZERO && ch <= CH_NINE) begin
						state_nxt = ST_PARAM;
						if (in_second_r) begin
							second_parameter_nxt = accum(second_parameter_r, ch);
							second_seen_nxt = 1'b1;
						end else begin
							first_parameter_nxt = accum(first_parameter_r, ch);
							first_seen_nxt = 1'b1;
						end
					end else if (ch == CH_SEMI && !in_second_r) begin
						state_nxt = ST_PARAM;
						in_second_nxt = 1'b1;
					end else if (ch == CH_UP_A) begin
						tmp = (8'(cur_r.row) > n) ? 8'(cur_r.row) - n : 8'h00;
						cur_nxt.row = tmp[4:0];
					end else if (ch == CH_UP_B) begin
						tmp = 8'(cur_r.row) + n;
						cur_nxt.row = (tmp > 8'(LAST_ROW)) ? LAST_ROW : tmp[4:0];
					end else if (ch == CH_UP_C) begin
						tmp = 8'(cur_r.col) + n;
						cur_nxt.col = (tmp > 8'(LAST_COL)) ? LAST_COL : tmp[6:0];
					end else if (ch == CH_UP_D) begin
						tmp = (8'(cur_r.col) > n) ? 8'(cur_r.col) - n : 8'h00;
						cur_nxt.col = tmp[6:0];
					end else if (ch == CH_UP_H || ch == CH_LO_F) begin
						tmp = count_of(second_parameter_r, second_seen_r);
						cur_nxt.row = (n > 8'(LAST_ROW) + 8'h01) ? LAST_ROW : 5'(n - 8'h01);
						cur_nxt.col = (tmp > 8'(LAST_COL) + 8'h01) ? LAST_COL : 7'(tmp - 8'h01);
					end else if (ch == CH_UP_J || ch == CH_UP_K) begin
						// omitted selector means zero
						blank_nxt.row_first = (ch == CH_UP_K || first_parameter_r == 8'(SEL_TO_END))
							? abs_row : cur_r.top;
						blank_nxt.row_last = (ch == CH_UP_K || first_parameter_r == 8'(SEL_TO_CUR))
							? abs_row : cur_r.top + 7'(LAST_ROW);
						blank_nxt.col_first = (first_parameter_r == 8'(SEL_TO_END)) ? cur_r.col : HOME_COL;
						blank_nxt.col_last = (first_parameter_r == 8'(SEL_TO_CUR)) ? cur_r.col : LAST_COL;
						if (first_parameter_r <= 8'(SEL_ALL)) begin
							state_nxt = ST_BLANK;
						end
					end
					// unknown finals abandon the sequence
				end
				default: state_nxt = ST_GROUND;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			state_r <= ST_GROUND;
			cur_r <= '{row: HOME_ROW, col: HOME_COL, top: TOP_RST};
			saved_r <= '{row: HOME_ROW, col: HOME_COL, top: TOP_RST};
			first_parameter_r <= 8'h00;
			second_parameter_r <= 8'h00;
			first_seen_r <= 1'b0;
			second_seen_r <= 1'b0;
			in_second_r <= 1'b0;
			blank_r <= '0;
			tx_pend_r <= 1'b0;
			beep_r <= 1'b0;
			test_r <= 1'b0;
			disp_r <= 7'h00;
			disp_v_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cur_r <= cur_nxt;
			saved_r <= saved_nxt;
			first_parameter_r <= first_parameter_nxt;
			second_parameter_r <= second_parameter_nxt;
			first_seen_r <= first_seen_nxt;
			second_seen_r <= second_seen_nxt;
			in_second_r <= in_second_nxt;
			blank_r <= blank_nxt;
			tx_pend_r <= tx_pend_nxt;
			beep_r <= beep_nxt;
			test_r <= test_nxt;
			disp_r <= disp_nxt;
			disp_v_r <= disp_v_nxt;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign tx_data_out     = CH_ACK;
	assign tx_valid_out    = tx_pend_r;
	assign cursor_out      = cur_r;
	assign blank_out       = blank_r;
	assign blank_valid_out = state_r == ST_BLANK;
	assign beep_out        = beep_r;
	assign self_test_out   = test_r;
	assign disp_data_out   = disp_r;
	assign disp_valid_out  = disp_v_r;

endmodule

// ### testbench/tei_interp_monitor.sv
/*
 * concurrent checks on the ports of tei_interp, bound into every instance.
 * assumes one clock clk_in and a synchronous active-high sys_rst_in.
 */
module tei_interp_monitor
	import tei_pkg::*;
(
	input wire logic           clk_in,
	input wire logic           sys_rst_in,
	input wire logic [7:0]     rx_data_in,
	input wire logic           rx_valid_in,
	input wire logic           rx_ready_out,
	input wire logic [6:0]     tx_data_out,
	input wire logic           tx_valid_out,
	input wire logic           tx_ready_in,
	input wire logic [6:0]     disp_data_out,
	input wire logic           disp_valid_out,
	input wire tei_cursor_type cursor_out,
	input wire tei_blank_type  blank_out,
	input wire logic           blank_valid_out,
	input wire logic           blank_ready_in,
	input wire logic           beep_out,
	input wire logic           self_test_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// handshake and range checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	// an answer offered but not yet taken
	sequence ack_waiting;
		tx_valid_out && !tx_ready_in;
	endsequence
	sequence blank_waiting;
		blank_valid_out && !blank_ready_in;
	endsequence
	chk_ack_holds: assert property (ack_waiting |=> tx_valid_out)
		else $error("ack withdrawn before taken");
	chk_ack_code: assert property (tx_valid_out |-> tx_data_out == CH_ACK)
		else $error("answer is not ack");
	chk_blank_holds: assert property (blank_waiting |=> blank_valid_out && $stable(blank_out))
		else $error("blank request changed while waiting");
	chk_parse_stalls: assert property (blank_waiting |=> !disp_valid_out && $stable(cursor_out))
		else $error("parsing went on during blank wait");
	chk_blank_span: assert property (blank_valid_out |-> blank_out.row_first <= blank_out.row_last
		&& blank_out.col_first <= blank_out.col_last && blank_out.col_last <= LAST_COL)
		else $error("blank span malformed");
	chk_cursor_range: assert property (cursor_out.col <= LAST_COL && cursor_out.row <= LAST_ROW)
		else $error("cursor off screen");
	chk_top_range: assert property (cursor_out.top <= TOP_LAST)
		else $error("window beyond fourth screen");
	chk_disp_print: assert property (disp_valid_out |-> disp_data_out >= CH_SPACE && disp_data_out != 7'h7F)
		else $error("control code displayed");
	chk_test_pulse: assert property (self_test_out |=> !self_test_out)
		else $error("self test strobe too long");
	chk_reset_state: assert property ($fell(sys_rst_in) |-> cursor_out == '0 && rx_ready_out
		&& !tx_valid_out && !blank_valid_out)
		else $error("state after reset wrong");
endmodule

bind tei_interp tei_interp_monitor i_tei_interp_monitor (
	.clk_in(clk_in), .sys_rst_in(sys_rst_in), .rx_data_in(rx_data_in), .rx_valid_in(rx_valid_in),
	.rx_ready_out(rx_ready_out), .tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out),
	.tx_ready_in(tx_ready_in), .disp_data_out(disp_data_out), .disp_valid_out(disp_valid_out),
	.cursor_out(cursor_out), .blank_out(blank_out), .blank_valid_out(blank_valid_out),
	.blank_ready_in(blank_ready_in), .beep_out(beep_out), .self_test_out(self_test_out)
);

// ### testbench/tei_host_model.sv
/*
 * host side: offers queued characters with valid/ready, takes acks.
 * assumes clk_in of the interpreter; ack_wait sets how slowly acks are taken.
 */
module tei_host_model
	import tei_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rx_ready_in,
	output logic      [7:0] rx_data_out,
	output logic            rx_valid_out,
	input  wire logic       tx_valid_in,
	output logic            tx_ready_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] q[$];
	int         ack_wait = 0;
	int         n_ack = 0;
	int         wait_r = 0;
	// ------------------------------------------------------------
	// character source and ack sink
	// ------------------------------------------------------------
	// escape sequences go out as escape then command bytes
	task automatic put(input string s);
		foreach (s[i]) q.push_back(s[i]);
	endtask
	// hold each character until taken; idle data toggles
	initial begin
		rx_valid_out = 1'b0;
		rx_data_out = 8'h00;
		tx_ready_out = 1'b0;
		forever begin
			@(posedge clk_in);
			if (rx_valid_out && rx_ready_in === 1'b1) void'(q.pop_front());
			if (tx_valid_in === 1'b1 && tx_ready_out) n_ack++;
			wait_r = (tx_valid_in === 1'b1 && !tx_ready_out) ? wait_r + 1 : 0;
			#1;
			rx_valid_out = q.size() > 0;
			rx_data_out = rx_valid_out ? q[0] : ~rx_data_out;
			tx_ready_out = tx_valid_in === 1'b1 && wait_r >= ack_wait;
		end
	end
endmodule

// ### testbench/tb.sv
/*
 * self-checking bench for tei_interp with a host model and a screen memory stub.
 * assumes a 125 MHz clock and reset held for 20 cycles.
 */
module tb;
	import tei_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic           clk_in = 1'b0;
	logic           sys_rst_in = 1'b1;
	logic [7:0]     rx_data_in;
	logic           rx_valid_in, rx_ready_out, tx_valid_out, tx_ready_in, disp_valid_out;
	logic           blank_valid_out, beep_out, self_test_out;
	logic           blank_ready_in = 1'b0;
	logic [6:0]     tx_data_out, disp_data_out, disp_last;
	tei_cursor_type cursor_out;
	tei_blank_type  blank_out, blk_seen;
	int             n_errors = 0;
	int             n_compared = 0;
	int             n_beep = 0;
	int             n_disp = 0;
	int             n_st = 0;
	int             blk_wait = 0;
	int             blk_cnt = 0;
	tei_interp i_tei_interp (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .rx_data_in(rx_data_in),
		.rx_valid_in(rx_valid_in), .rx_ready_out(rx_ready_out), .tx_data_out(tx_data_out),
		.tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in), .disp_data_out(disp_data_out),
		.disp_valid_out(disp_valid_out), .cursor_out(cursor_out), .blank_out(blank_out),
		.blank_valid_out(blank_valid_out), .blank_ready_in(blank_ready_in), .beep_out(beep_out),
		.self_test_out(self_test_out));
	tei_host_model i_tei_host_model (.clk_in(clk_in), .rx_ready_in(rx_ready_out), .rx_data_out(rx_data_in),
		.rx_valid_out(rx_valid_in), .tx_valid_in(tx_valid_out), .tx_ready_out(tx_ready_in));
	// ------------------------------------------------------------
	// clock, screen memory stub, pulse counters
	// ------------------------------------------------------------
	initial begin
		forever #4 clk_in = ~clk_in;
	end
	// screen memory accepts a blank request after blk_wait cycles
	always @(posedge clk_in) begin
		if (blank_valid_out === 1'b1 && blank_ready_in) blk_seen = blank_out;
		blk_cnt = (blank_valid_out === 1'b1 && !blank_ready_in) ? blk_cnt + 1 : 0;
		if (beep_out === 1'b1) n_beep++;
		if (disp_valid_out === 1'b1) n_disp++;
		if (disp_valid_out === 1'b1) disp_last = disp_data_out;
		if (self_test_out === 1'b1) n_st++;
		#1;
		blank_ready_in = blank_valid_out === 1'b1 && blk_cnt >= blk_wait;
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// send a string and wait until it has been taken and acted on
	task automatic run(input string s);
		i_tei_host_model.put(s);
		for (int i = 0; i < 3000 && i_tei_host_model.q.size() > 0; i++) begin
			@(posedge clk_in);
			#1;
		end
		repeat (4) @(posedge clk_in);
		#1;
	endtask
	task automatic summarize;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_move;
		string s[15] = '{"\033[5;10H", "\033[2A", "\033[3B", "\033[4C", "\033[D", "\033[0A", "\033[99;99H",
			"\033[C", "\033[9B", "\033[H", "\033[5D", "\033[A", "\033[3;4f", "\0337\033[9;9H\0338", "\033[3Z\033[C"};
		logic [11:0] e[15] = '{{5'h04, 7'h09}, {5'h02, 7'h09}, {5'h05, 7'h09}, {5'h05, 7'h0D}, {5'h05, 7'h0C},
			{5'h04, 7'h0C}, {5'h17, 7'h4F}, {5'h17, 7'h4F}, {5'h17, 7'h4F}, {5'h00, 7'h00}, {5'h00, 7'h00},
			{5'h00, 7'h00}, {5'h02, 7'h03}, {5'h02, 7'h03}, {5'h02, 7'h04}};
		for (int i = 0; i < 15; i++) begin
			run(s[i]);
			chk(cursor_out, {e[i], 7'h00});
		end
	endtask
	task automatic t_ctrl;
		int d0 = n_disp;
		int b0 = n_beep;
		int a0 = i_tei_host_model.n_ack;
		run("\015\010AB\010\012\007\001\177\033Q\033[3Z");
		chk(cursor_out, {5'h03, 7'h01, 7'h00});
		chk(n_disp - d0, 2);
		chk(disp_last, 7'h42);
		chk(n_beep - b0, 1);
		i_tei_host_model.ack_wait = 5;
		run("\005");
		chk(tx_valid_out, 1);
		chk(tx_data_out, CH_ACK);
		for (int i = 0; i < 50 && i_tei_host_model.n_ack == a0; i++) @(posedge clk_in);
		chk(i_tei_host_model.n_ack - a0, 1);
	endtask
	task automatic t_scroll;
		string s[6] = '{"\033[24;1H\033D", "\033[1;1H\033M", "\033M", "\033[24;1H", "\033[1;1H\033M", "\033[5;9H\033E"};
		logic [18:0] e[6] = '{{5'h17, 7'h00, 7'h01}, {5'h00, 7'h00, 7'h00}, {5'h00, 7'h00, 7'h00},
			{5'h17, 7'h00, 7'h48}, {5'h00, 7'h00, 7'h47}, {5'h05, 7'h00, 7'h47}};
		for (int i = 0; i < 73; i++) s[3] = {s[3], "\033D"};
		for (int i = 0; i < 6; i++) begin
			run(s[i]);
			chk(cursor_out, e[i]);
		end
	endtask
	task automatic t_blank;
		string s[4] = '{"\033[2J", "\033[6;11H\033[K", "\033[1K", "\033[2K"};
		logic [27:0] e[4] = '{{7'h47, 7'h5E, 7'h00, 7'h4F}, {7'h4C, 7'h4C, 7'h0A, 7'h4F},
			{7'h4C, 7'h4C, 7'h00, 7'h0A}, {7'h4C, 7'h4C, 7'h00, 7'h4F}};
		blk_wait = 2;
		for (int i = 0; i < 4; i++) begin
			run(s[i]);
			chk(blk_seen, e[i]);
		end
	endtask
	// blank held off: fifo fills and refuses, then drains
	task automatic t_fifo;
		run("\033[1;1H");
		blk_wait = 1000000;
		i_tei_host_model.put("\033[2J");
		for (int i = 0; i < 100; i++) i_tei_host_model.put("x");
		for (int i = 0; i < 300 && rx_ready_out === 1'b1; i++) begin
			@(posedge clk_in);
			#1;
		end
		repeat (20) @(posedge clk_in);
		#1;
		chk(rx_ready_out, 0);
		chk(cursor_out, {5'h00, 7'h00, 7'h47});
		blk_wait = 0;
		run("");
		// the host queue empties while up to 32 characters still wait in the fifo
		repeat (40) @(posedge clk_in);
		#1;
		chk(cursor_out, {5'h00, 7'h4F, 7'h47});
		chk(rx_ready_out, 1);
	endtask
	task automatic t_reset;
		int t0 = n_st;
		run("\033[4;4H\0337\033c");
		chk(cursor_out, 0);
		chk(n_st - t0, 1);
		chk(blk_seen, {7'h00, 7'h5F, 7'h00, 7'h4F});
		run("\033[9;9H\0338");
		chk(cursor_out, 0);
	endtask
	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk_in);
		#1;
		sys_rst_in = 1'b0;
		@(posedge clk_in);
		#1;
		chk(rx_ready_out, 1);
		t_move;
		t_ctrl;
		t_scroll;
		t_blank;
		t_fifo;
		t_reset;
		summarize;
	end
	initial begin
		#400000;
		n_errors++;
		summarize;
	end
endmodule
